// ---- rtl/pal_pkg.sv ----
package pal_pkg;
  // ==========================================
  // Port numbering and sizes
  // ==========================================
  localparam int unsigned NUM_PORTS = 4;     // Ports one to four
  localparam int unsigned PORT_W = 2;        // Port index width (port number minus one)
  localparam int unsigned TMR_W = 24;        // Width of the per-port timer period
  localparam int unsigned STOP_W = 3;        // Optional stop conditions per port
  // Field positions inside a stop-condition vector
  localparam int unsigned STOP_EXEC_BIT = 0;    // Command executed or failed
  localparam int unsigned STOP_INVALID_BIT = 1; // Invalid command name
  localparam int unsigned STOP_CARRIER_BIT = 2; // Carrier drop after a digit
  // ==========================================
  // Reset values (factory state)
  // ==========================================
  localparam logic [NUM_PORTS-1:0] PREACC_RST = 4'h0; // No port requires preaccess
  localparam logic [STOP_W-1:0] STOP_RST = 3'h0;      // All optional stops off
  localparam logic [TMR_W-1:0] TMR_RST = 24'h000000;  // Timer idle
  // ==========================================
  // Command codes presented on the command strobe
  // ==========================================
  typedef enum logic [2:0] {
    PAL_CMD_NONE,
    PAL_CMD_DISABLE,
    PAL_CMD_REQUIRE,
    PAL_CMD_QUERY,
    PAL_CMD_GRANT,
    PAL_CMD_STOP_SET,
    PAL_CMD_STOP_QUERY,
    PAL_CMD_ISOLATE
  } pal_cmd_t;
endpackage

// ---- rtl/pal_port_timer.sv ----
`timescale 1ns/100ps
// ==========================================
// One port's preaccess timer and access state
// ==========================================
module pal_port_timer
  import pal_pkg::*;
#(
  parameter int unsigned TW = TMR_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [TW-1:0] period_in,   // Programmed timer length in cycles
  input wire logic start_in,             // Access code, grant or isolate
  input wire logic isolate_in,           // Start also isolates the port
  input wire logic digit_held_in,        // Digit currently pressed (synchronised)
  input wire logic digit_rel_in,         // One-cycle digit release
  input wire logic carrier_in,           // Carrier detect (synchronised)
  input wire logic exec_in,              // Command executed or failed
  input wire logic invalid_in,           // Invalid command name
  input wire logic [STOP_W-1:0] stop_en_in, // Optional stop enables
  output logic accessed_out,             // Port is open for commands
  output logic isolated_out              // Port is isolated
);
  // ==========================================
  // State
  // ==========================================
  logic [TW-1:0] cnt_r;        // Cycles remaining
  logic acc_r;                 // Accessed flag
  logic iso_r;                 // Isolation active
  logic dig_seen_r;            // A digit came after the access code
  logic carrier_d_r;           // Carrier one cycle ago, for drop detection
  // Decode of the closing events
  wire carrier_drop = carrier_d_r & ~carrier_in;
  wire expire = acc_r & (cnt_r == '0) & ~digit_held_in;
  wire stop_exec = stop_en_in[STOP_EXEC_BIT] & exec_in;
  wire stop_inval = stop_en_in[STOP_INVALID_BIT] & invalid_in;
  wire stop_carr = stop_en_in[STOP_CARRIER_BIT] & dig_seen_r & carrier_drop;
  // Expiry closes regardless of the optional enables
  wire close = expire | stop_exec | stop_inval | stop_carr;
  wire reload = start_in | (acc_r & digit_rel_in);
  // Start wins over a close in the same cycle so a fresh code is never lost
  // ==========================================
  // Timer and flags
  // ==========================================
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
      acc_r <= 1'b0;
      iso_r <= 1'b0;
      dig_seen_r <= 1'b0;
      carrier_d_r <= 1'b0;
    end else begin
      carrier_d_r <= carrier_in;
      if (reload) begin
        // Restart full period
        cnt_r <= period_in;
      end else if (acc_r && cnt_r != '0 && !digit_held_in) begin
        // Count down only while no digit is held
        cnt_r <= cnt_r - 1'b1;
      end
      if (start_in) begin
        acc_r <= 1'b1;
        iso_r <= iso_r | isolate_in;
        dig_seen_r <= 1'b0;
      end else if (close) begin
        // Closing requires a new access code, grant or isolate
        acc_r <= 1'b0;
        iso_r <= 1'b0;
        dig_seen_r <= 1'b0;
      end else if (acc_r && digit_rel_in) begin
        dig_seen_r <= 1'b1;
      end
    end
  end
  assign accessed_out = acc_r;
  assign isolated_out = iso_r;
endmodule // pal_port_timer

// ---- rtl/pal_lock_ctrl.sv ----
`timescale 1ns/100ps
module pal_lock_ctrl
  import pal_pkg::*;
#(
  parameter int unsigned NP = NUM_PORTS,
  parameter int unsigned TW = TMR_W
) (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // Command strobe from the command decoder
  input wire logic CMD_VALID_IN,
  input wire pal_pkg::pal_cmd_t CMD_CODE_IN,
  input wire logic [pal_pkg::PORT_W-1:0] CMD_SRC_PORT_IN,  // Port command came from
  input wire logic [pal_pkg::PORT_W-1:0] CMD_ARG_PORT_IN,  // Selected port argument
  input wire logic [pal_pkg::STOP_W-1:0] CMD_STOP_IN,      // Enables for stop set
  // Access code and decoder events, per port
  input wire logic [NP-1:0] ACCESS_CODE_IN,    // Access code recognised
  input wire logic [NP-1:0] EXEC_EVT_IN,       // Command executed or failed
  input wire logic [NP-1:0] INVALID_EVT_IN,    // Digits not a command name
  input wire logic [NP-1:0] DIGIT_HELD_IN,     // DTMF digit pressed (pins)
  input wire logic [NP-1:0] CARRIER_DETECT_IN, // Receiver carrier (pins)
  input wire logic [NP*TW-1:0] TMR_PERIOD_IN,  // Per-port period in cycles
  // Crosspoint mask inputs, stored routing per port
  input wire logic [NP*NP-1:0] XPT_AUDIO_IN,
  input wire logic [NP*NP-1:0] XPT_PTT_IN,
  // Results
  output logic [NP-1:0] CMD_ALLOW_OUT,         // Commands accepted per port
  output logic [NP-1:0] PREACC_REQ_OUT,        // Ports requiring preaccess
  output logic [NP-1:0] ACCESSED_OUT,
  output logic [NP-1:0] ISOLATED_OUT,
  output logic [NP*NP-1:0] XPT_AUDIO_OUT,      // Effective routing
  output logic [NP*NP-1:0] XPT_PTT_OUT,
  output logic REPLY_VALID_OUT,                // One-cycle reply pulse
  output logic [NP-1:0] REPLY_PORTS_OUT,       // Query result bitmap
  output logic REPLY_NONE_OUT,                 // No port requires preaccess
  output logic [pal_pkg::PORT_W-1:0] REPLY_PORT_OUT,
  output logic [pal_pkg::STOP_W-1:0] REPLY_STOP_OUT
);
  import pal_pkg::*;
  // ==========================================
  // Pin synchronisers: three stages, second and third agree
  // ==========================================
  logic [NP-1:0] held_s1_r, held_s2_r, held_s3_r, held_r;
  logic [NP-1:0] car_s1_r, car_s2_r, car_s3_r, car_r;
  logic [NP-1:0] held_nxt, car_nxt;
  // Release is the falling edge of the agreed digit level
  wire [NP-1:0] held_rel = held_r & ~held_nxt;
  // A change is accepted only when stages two and three agree
  assign held_nxt = (held_s2_r == held_s3_r) ? held_s3_r : held_r;
  assign car_nxt = (car_s2_r == car_s3_r) ? car_s3_r : car_r;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      held_s1_r <= '0;
      held_s2_r <= '0;
      held_s3_r <= '0;
      held_r <= '0;
      car_s1_r <= '0;
      car_s2_r <= '0;
      car_s3_r <= '0;
      car_r <= '0;
    end else begin
      held_s1_r <= DIGIT_HELD_IN;
      held_s2_r <= held_s1_r;
      held_s3_r <= held_s2_r;
      held_r <= held_nxt;
      car_s1_r <= CARRIER_DETECT_IN;
      car_s2_r <= car_s1_r;
      car_s3_r <= car_s2_r;
      car_r <= car_nxt;
    end
  end
  // ==========================================
  // Command decode
  // ==========================================
  wire c_disable = CMD_VALID_IN & (CMD_CODE_IN == PAL_CMD_DISABLE);
  wire c_require = CMD_VALID_IN & (CMD_CODE_IN == PAL_CMD_REQUIRE);
  wire c_query = CMD_VALID_IN & (CMD_CODE_IN == PAL_CMD_QUERY);
  wire c_grant = CMD_VALID_IN & (CMD_CODE_IN == PAL_CMD_GRANT);
  wire c_stopset = CMD_VALID_IN & (CMD_CODE_IN == PAL_CMD_STOP_SET);
  wire c_stopq = CMD_VALID_IN & (CMD_CODE_IN == PAL_CMD_STOP_QUERY);
  wire c_iso = CMD_VALID_IN & (CMD_CODE_IN == PAL_CMD_ISOLATE);
  // Per-port config state
  logic [NP-1:0] preacc_r;                // Ports requiring preaccess
  logic [STOP_W-1:0] stop_en_r [NP];      // Three stop enables per port
  logic [NP-1:0] acc_w, iso_w;
  // Commands from a locked port are refused, grant and isolate included;
  // only the access code strobe, or an isolate from an open port that selects it, can open a locked port
  wire src_ok = ~preacc_r[CMD_SRC_PORT_IN] | acc_w[CMD_SRC_PORT_IN];
  wire ctl_ok = src_ok;
  // ==========================================
  // Preaccess requirement and stop enables
  // ==========================================
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      preacc_r <= PREACC_RST;
      for (int i = 0; i < NP; i++) begin
        stop_en_r[i] <= STOP_RST;
      end
    end else begin
      if (c_disable && ctl_ok) begin
        // Back to factory non-preaccess link
        preacc_r[CMD_ARG_PORT_IN] <= 1'b0;
      end else if (c_require && ctl_ok) begin
        preacc_r[CMD_ARG_PORT_IN] <= 1'b1;
      end
      if (c_stopset && ctl_ok) begin
        stop_en_r[CMD_ARG_PORT_IN] <= CMD_STOP_IN;
      end
    end
  end
  // ==========================================
  // Per-port timers
  // ==========================================
  for (genvar p = 0; p < NP; p++) begin : g_port
    wire own = (CMD_SRC_PORT_IN == PORT_W'(p));
    wire sel = (CMD_ARG_PORT_IN == PORT_W'(p));
    // Access code, grant from own port, or isolate of selected port
    // Isolate is a command too, so a locked source cannot trigger it
    wire iso_go = c_iso & ctl_ok & sel;
    wire start = (ACCESS_CODE_IN[p] & preacc_r[p]) | (c_grant & ctl_ok & own) | iso_go;
    pal_port_timer #(
      .TW(TW)
    ) u_tmr (
      .clk_in(REF_CLK_IN),
      .nrst_in(NRST_IN),
      .period_in(TMR_PERIOD_IN[p*TW +: TW]),
      .start_in(start),
      .isolate_in(iso_go),
      .digit_held_in(held_r[p]),
      .digit_rel_in(held_rel[p]),
      .carrier_in(car_r[p]),
      .exec_in(EXEC_EVT_IN[p]),
      .invalid_in(INVALID_EVT_IN[p]),
      .stop_en_in(stop_en_r[p]),
      .accessed_out(acc_w[p]),
      .isolated_out(iso_w[p])
    );
  end
  // ==========================================
  // Crosspoint masking: stored routing is untouched
  // ==========================================
  logic [NP*NP-1:0] xmask;
  always_comb begin
    xmask = '0;
    for (int s = 0; s < NP; s++) begin
      for (int d = 0; d < NP; d++) begin
        // Cut any path that touches an isolated port, except to itself
        xmask[s*NP+d] = (s != d) & (iso_w[s] | iso_w[d]);
      end
    end
  end
  assign XPT_AUDIO_OUT = XPT_AUDIO_IN & ~xmask;
  assign XPT_PTT_OUT = XPT_PTT_IN & ~xmask;
  assign CMD_ALLOW_OUT = ~preacc_r | acc_w;
  assign PREACC_REQ_OUT = preacc_r;
  assign ACCESSED_OUT = acc_w;
  assign ISOLATED_OUT = iso_w;
  // ==========================================
  // Replies: grant and isolate give none
  // ==========================================
  logic rv_r;
  logic [NP-1:0] rports_r;
  logic rnone_r;
  logic [PORT_W-1:0] rport_r;
  logic [STOP_W-1:0] rstop_r;
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rv_r <= 1'b0;
      rports_r <= '0;
      rnone_r <= 1'b0;
      rport_r <= '0;
      rstop_r <= '0;
    end else begin
      rv_r <= (c_query | c_stopq) & ctl_ok;
      if (c_query && ctl_ok) begin
        rports_r <= preacc_r;
        rnone_r <= (preacc_r == '0);
      end
      if (c_stopq && ctl_ok) begin
        rport_r <= CMD_ARG_PORT_IN;
        rstop_r <= stop_en_r[CMD_ARG_PORT_IN];
      end
    end
  end
  assign REPLY_VALID_OUT = rv_r;
  assign REPLY_PORTS_OUT = rports_r;
  assign REPLY_NONE_OUT = rnone_r;
  assign REPLY_PORT_OUT = rport_r;
  assign REPLY_STOP_OUT = rstop_r;
endmodule // pal_lock_ctrl

// ---- test/pal_lock_ctrl_properties.sv ----
`timescale 1ns/100ps
// ========
// Port-side checker for the access gating block
module pal_lock_props
  import pal_pkg::*;
#(
  parameter int unsigned NP = NUM_PORTS
) (
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CMD_VALID_IN,
  input wire pal_pkg::pal_cmd_t CMD_CODE_IN,
  input wire logic [pal_pkg::PORT_W-1:0] CMD_SRC_PORT_IN,
  input wire logic [pal_pkg::PORT_W-1:0] CMD_ARG_PORT_IN,
  input wire logic [NP-1:0] ACCESS_CODE_IN,
  input wire logic [NP*NP-1:0] XPT_AUDIO_IN,
  input wire logic [NP*NP-1:0] XPT_PTT_IN,
  input wire logic [NP-1:0] CMD_ALLOW_OUT,
  input wire logic [NP-1:0] PREACC_REQ_OUT,
  input wire logic [NP-1:0] ACCESSED_OUT,
  input wire logic [NP-1:0] ISOLATED_OUT,
  input wire logic [NP*NP-1:0] XPT_AUDIO_OUT,
  input wire logic [NP*NP-1:0] XPT_PTT_OUT,
  input wire logic REPLY_VALID_OUT,
  input wire logic [NP-1:0] REPLY_PORTS_OUT,
  input wire logic REPLY_NONE_OUT,
  input wire logic [pal_pkg::PORT_W-1:0] REPLY_PORT_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // A command counts only when its source port is open
  wire tk = CMD_VALID_IN && CMD_ALLOW_OUT[CMD_SRC_PORT_IN];
  wire qq = tk && (CMD_CODE_IN == PAL_CMD_QUERY || CMD_CODE_IN == PAL_CMD_STOP_QUERY);
  sequence q_tk; tk && CMD_CODE_IN == PAL_CMD_QUERY; endsequence
  sequence sq_tk; tk && CMD_CODE_IN == PAL_CMD_STOP_QUERY; endsequence
  sequence mute_tk; tk && (CMD_CODE_IN == PAL_CMD_GRANT || CMD_CODE_IN == PAL_CMD_ISOLATE); endsequence
  allow_map_a: assert property (CMD_ALLOW_OUT == (~PREACC_REQ_OUT | ACCESSED_OUT))
    else $error("allow map wrong");
  query_map_a: assert property (q_tk |=> REPLY_VALID_OUT && REPLY_PORTS_OUT == $past(PREACC_REQ_OUT)
    && REPLY_NONE_OUT == ($past(PREACC_REQ_OUT) == '0)) else $error("query reply wrong");
  stop_port_a: assert property (sq_tk |=> REPLY_VALID_OUT && REPLY_PORT_OUT == $past(CMD_ARG_PORT_IN))
    else $error("stop query port wrong");
  silent_cmd_a: assert property (mute_tk |=> !REPLY_VALID_OUT) else $error("grant replied");
  reply_cause_a: assert property (REPLY_VALID_OUT |-> $past(qq)) else $error("stray reply");
  disable_clr_a: assert property (tk && CMD_CODE_IN == PAL_CMD_DISABLE |=>
    !PREACC_REQ_OUT[$past(CMD_ARG_PORT_IN)]) else $error("disable kept preaccess");
  code_open_a: assert property (ACCESS_CODE_IN[0] && PREACC_REQ_OUT[0] |=> ACCESSED_OUT[0])
    else $error("code did not open");
  lock_hold_a: assert property (!ACCESSED_OUT[0] && !ACCESS_CODE_IN[0] && !CMD_VALID_IN
    |=> !ACCESSED_OUT[0]) else $error("opened without code");
  grant_refused_a: assert property (CMD_VALID_IN && CMD_CODE_IN == PAL_CMD_GRANT
    && !CMD_ALLOW_OUT[CMD_SRC_PORT_IN] && CMD_SRC_PORT_IN == '0 && !ACCESS_CODE_IN[0]
    |=> !ACCESSED_OUT[0]) else $error("locked grant opened");
  xpt_pass_a: assert property (ISOLATED_OUT == '0 |-> XPT_AUDIO_OUT == XPT_AUDIO_IN
    && XPT_PTT_OUT == XPT_PTT_IN) else $error("routing changed");
endmodule // pal_lock_props
bind pal_lock_ctrl pal_lock_props #(.NP(NP)) u_props (.REF_CLK_IN, .NRST_IN, .CMD_VALID_IN,
  .CMD_CODE_IN, .CMD_SRC_PORT_IN, .CMD_ARG_PORT_IN, .ACCESS_CODE_IN, .XPT_AUDIO_IN,
  .XPT_PTT_IN, .CMD_ALLOW_OUT, .PREACC_REQ_OUT, .ACCESSED_OUT, .ISOLATED_OUT,
  .XPT_AUDIO_OUT, .XPT_PTT_OUT, .REPLY_VALID_OUT, .REPLY_PORTS_OUT, .REPLY_NONE_OUT,
  .REPLY_PORT_OUT);

// ---- test/pal_operator.sv ----
`timescale 1ns/100ps
// ========
// Operator keying a receiver and sending DTMF digits
module pal_operator (
  input wire logic clk_in,
  output logic [3:0] digit_out,
  output logic [3:0] carrier_out,
  output logic [3:0] code_out
);
  initial begin
    digit_out = 4'h0;
    carrier_out = 4'h0;
    code_out = 4'h0;
  end
  // Key up and hold one digit for n cycles
  task automatic press(input int p, input int n);
    @(posedge clk_in);
    carrier_out[p] <= 1'h1;
    digit_out[p] <= 1'h1;
    repeat (n) @(posedge clk_in);
    digit_out[p] <= 1'h0;
  endtask
  // Single star digit, then the decoder flags the access code
  task automatic send_code(input int p);
    press(p, 3);
    @(posedge clk_in);
    code_out[p] <= 1'h1;
    @(posedge clk_in);
    code_out[p] <= 1'h0;
  endtask
  task automatic unkey(input int p);
    @(posedge clk_in);
    carrier_out[p] <= 1'h0;
  endtask
endmodule // pal_operator

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import pal_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic cv = 1'h0;
  pal_cmd_t cc = PAL_CMD_NONE;
  logic [1:0] cs = 2'h0;
  logic [1:0] ca = 2'h0;
  logic [2:0] cst = 3'h0;
  logic [3:0] ex = 4'h0;
  logic [3:0] inv = 4'h0;
  logic [15:0] xa = 16'hffff;
  logic [15:0] xp = 16'h5a5a;
  wire [3:0] dh, car, acc, allow, preq, accd, isod, rp;
  wire [15:0] xao, xpo;
  wire rv, rn;
  wire [1:0] rpt;
  wire [2:0] rs;
  int failures = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  pal_operator op (.clk_in(clk), .digit_out(dh), .carrier_out(car), .code_out(acc));
  // Short timer period of 20 cycles keeps the run brief
  pal_lock_ctrl DUT (.REF_CLK_IN(clk), .NRST_IN(nrst), .CMD_VALID_IN(cv), .CMD_CODE_IN(cc),
    .CMD_SRC_PORT_IN(cs), .CMD_ARG_PORT_IN(ca), .CMD_STOP_IN(cst), .ACCESS_CODE_IN(acc),
    .EXEC_EVT_IN(ex), .INVALID_EVT_IN(inv), .DIGIT_HELD_IN(dh), .CARRIER_DETECT_IN(car),
    .TMR_PERIOD_IN({4{24'h000014}}), .XPT_AUDIO_IN(xa), .XPT_PTT_IN(xp),
    .CMD_ALLOW_OUT(allow), .PREACC_REQ_OUT(preq), .ACCESSED_OUT(accd), .ISOLATED_OUT(isod),
    .XPT_AUDIO_OUT(xao), .XPT_PTT_OUT(xpo), .REPLY_VALID_OUT(rv), .REPLY_PORTS_OUT(rp),
    .REPLY_NONE_OUT(rn), .REPLY_PORT_OUT(rpt), .REPLY_STOP_OUT(rs));
  task automatic chk(string n, logic [23:0] s, logic [23:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  // One command strobe, taken at the second edge
  task automatic cmd(pal_cmd_t c, logic [1:0] s, logic [1:0] a, logic [2:0] st = 3'h0);
    @(posedge clk);
    cv <= 1'h1;
    cc <= c;
    cs <= s;
    ca <= a;
    cst <= st;
    @(posedge clk);
    cv <= 1'h0;
    #1;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_lock;
    cmd(PAL_CMD_QUERY, 2'h0, 2'h0);
    chk("none", rn, 1'h1);
    cmd(PAL_CMD_REQUIRE, 2'h1, 2'h0);
    cmd(PAL_CMD_QUERY, 2'h1, 2'h0);
    chk("ports", {rn, rp}, 5'h01);
    cmd(PAL_CMD_GRANT, 2'h0, 2'h0);
    chk("locked", accd, 4'h0);
    op.send_code(0);
    wt(12);
    chk("open", accd, 4'h1);
    cmd(PAL_CMD_GRANT, 2'h0, 2'h0);
    chk("grant quiet", rv, 1'h0);
    wt(16);
    chk("grant hold", accd, 4'h1);
    wt(20);
    chk("expired", accd, 4'h0);
  endtask
  task automatic t_hold;
    op.send_code(0);
    op.press(0, 40);
    wt(0);
    chk("held", accd, 4'h1);
    wt(23);
    chk("restart", accd, 4'h1);
    wt(20);
    chk("closed", accd, 4'h0);
  endtask
  task automatic t_stops;
    for (int i = 0; i < 3; i++) begin
      cmd(PAL_CMD_STOP_SET, 2'h1, 2'h0, 3'h1 << i);
      cmd(PAL_CMD_STOP_QUERY, 2'h1, 2'h0);
      chk("stop query", {rpt, rs}, 3'h1 << i);
      op.send_code(0);
      wt(1);
      chk("reopen", accd, 4'h1);
      @(posedge clk);
      ex[0] <= (i == 0);
      inv[0] <= (i == 1);
      @(posedge clk);
      ex[0] <= 1'h0;
      inv[0] <= 1'h0;
      if (i == 2) begin
        op.press(0, 2);
        op.unkey(0);
      end
      wt(10);
      chk("stopped", accd, 4'h0);
    end
  endtask
  task automatic t_iso;
    cmd(PAL_CMD_ISOLATE, 2'h1, 2'h1);
    chk("iso", {rv, isod}, 5'h02);
    chk("iso audio", xao, 16'hdd2d);
    chk("iso ptt", xpo, 16'h5808);
    wt(30);
    chk("iso end", {isod, xao}, 20'h0ffff);
    chk("ptt back", xpo, 16'h5a5a);
  endtask
  task automatic t_dis;
    cmd(PAL_CMD_DISABLE, 2'h1, 2'h0);
    chk("disabled", {preq, allow}, 8'h0f);
    cmd(PAL_CMD_QUERY, 2'h2, 2'h0);
    chk("none again", rn, 1'h1);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    t_lock();
    t_hold();
    t_stops();
    t_iso();
    t_dis();
    close_out();
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #40000;
    failures++;
    close_out();
  end
endmodule // testbench
